// >>> logic/tc_word_map_consts.vh
`ifndef TC_WORD_MAP_CONSTS_VH
`define TC_WORD_MAP_CONSTS_VH
// ****************************************
// Word indices of the register port
// ****************************************
`define IDX_CH_FIRST 4'h0
`define IDX_CH_LAST 4'h7
`define IDX_STATUS 4'h8
`define IDX_INTERNAL 4'h9
`define IDX_CONFIG 4'ha
`define IDX_TYPE_LO 4'hb
`define IDX_TYPE_HI 4'hc
`define IDX_IRQ_STAT 4'hd
`define IDX_IRQ_MASK 4'he
`define NUM_WORDS 4'ha
// ****************************************
// Field positions and reset values
// ****************************************
`define CFG_WHOLE_BIT 0
`define CFG_FAHR_BIT 1
`define CFG_RESET 16'h0000
`define TYPE_RESET 16'h0000
`define MASK_RESET 16'h0000
`define CJ_CHAN 4'h8
// ****************************************
// Sensor type codes (3 bits, bit 3 = open test for linear)
// ****************************************
`define TYPE_J 3'h0
`define TYPE_K 3'h1
`define TYPE_E 3'h2
`define TYPE_T 3'h3
`define TYPE_S 3'h4
`define TYPE_R 3'h5
`define TYPE_B 3'h6
`define TYPE_LIN 3'h7
// ****************************************
// Saturation codes and linear fault code
// ****************************************
`define CODE_OVER 16'h7fff
`define CODE_UNDER 16'h8001
`define CODE_LIN_FAULT 16'hffff
// ****************************************
// Thresholds in tenths of degrees C: minimum, rated, fault
// ****************************************
`define J_MIN (-16'sh08ed)
`define J_RATED 16'sh1db0
`define J_FAULT 16'sh1e6b
`define K_MIN (-16'sh0bd5)
`define K_RATED 16'sh3584
`define K_FAULT 16'sh36e3
`define E_MIN (-16'sh0b7a)
`define E_RATED 16'sh2710
`define E_FAULT 16'sh2800
`define T_MIN (-16'sh0aeb)
`define T_RATED 16'sh0fa0
`define T_FAULT 16'sh1001
`define S_MIN (-16'sh0383)
`define S_RATED 16'sh410a
`define S_FAULT 16'sh429b
`define R_MIN (-16'sh0380)
`define R_RATED 16'sh410a
`define R_FAULT 16'sh4298
`define B_MIN 16'sh0360
`define B_RATED 16'sh4718
`define B_FAULT 16'sh48ce
`endif

// >>> logic/word_store.v
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Small word memory with registered read data
// ****************************************
module word_store #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire re_i,
  input wire [AW-1:0] raddr_i,
  output reg [WIDTH-1:0] rdata_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array

  // Write port
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read port, data stands one cycle after the strobe
  always @(posedge clk_i) begin
    if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // word_store
`default_nettype wire

// >>> logic/temp_format.v
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Unit and resolution converter, one cycle latency
// ****************************************
module temp_format (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  input wire signed [15:0] in_temp_i,
  input wire fahr_i,
  input wire whole_i,
  output reg out_valid_o,
  output reg [15:0] out_val_o
);
  wire signed [20:0] cels; // Tenths of C, widened
  wire signed [20:0] fahr; // Tenths of F
  wire signed [20:0] tenths; // Selected scale
  wire signed [20:0] result; // Selected resolution

  assign cels = {{5{in_temp_i[15]}}, in_temp_i};
  // Scale choice, F = C * 9 / 5 + 32 in tenths
  assign fahr = ((cels * 21'sh9) / 21'sh5) + 21'sh140;
  assign tenths = fahr_i ? fahr : cels;
  // Whole degrees drop the implied decimal digit
  assign result = whole_i ? (tenths / 21'sha) : tenths;

  // Output register
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_val_o <= 16'h0000;
    end else begin
      out_valid_o <= in_valid_i;
      // Low 16 bits: two's complement, or unsigned for large values
      out_val_o <= result[15:0];
    end
  end
endmodule // temp_format
`default_nettype wire

// >>> logic/tc_word_map.v
// Function
// - Ten contiguous 16-bit input words presented
// - Words: eight channels, status, internal temperature
// - Warning flag when above rated input
// - Fault flag beyond margin or broken wire
// - Fault flag clears the warning flag
// - Select tenths or whole, Celsius or Fahrenheit
// - Tenths reported as integer, decimal implied
// - Internal reading uses same units
// - Readings signed except the Type B case
// - Open sensor sets fault, clears warning
// - Over range forces maximum code
// - Under range forces minimum code
// - Type B tenths Fahrenheit encoded unsigned
// - Open test always on for thermocouples
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "tc_word_map_consts.vh"
module tc_word_map (
  input wire REF_CLK_I,
  input wire SYS_RST_I,
  input wire [3:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output wire [15:0] RDATA_O,
  output wire IRQ_O,
  input wire CONV_VALID_I,
  input wire [3:0] CONV_CHAN_I,
  input wire [15:0] CONV_DATA_I,
  input wire CONV_OPEN_I
);
  // ****************************************
  // Declarations
  // ****************************************
  reg [15:0] fmt_cfg; // Resolution and scale select
  reg [15:0] type_lo; // Sensor setup, channels 1-4
  reg [15:0] type_hi; // Sensor setup, channels 5-8
  reg [15:0] irq_stat; // Sticky event bits
  reg [15:0] irq_mask; // Event enables
  reg [7:0] warn; // Range warning per channel
  reg [7:0] fault; // Fault per channel: out of range or open wire
  reg [9:0] written; // Word has been filled once
  reg rd_other; // Last cycle was not a memory read
  reg [15:0] rd_hold; // Read data for non-memory words
  reg s_chan_ok; // Stage: sample for a sensor channel
  reg s_cj; // Stage: sample for the internal reading
  reg [2:0] s_idx; // Stage: channel index
  reg s_over; // Stage: at or above fault limit, or open wire when not below minimum
  reg s_under; // Stage: below minimum reading
  reg s_warn; // Stage: warning flag
  reg s_fault; // Stage: fault flag
  reg s_lin; // Stage: linear range, raw data
  reg [15:0] s_raw; // Stage: raw sample
  reg [15:0] next_stat; // Next sticky status
  reg [15:0] word; // Word written to memory
  reg [3:0] word_idx; // Memory index for the word
  reg [3:0] sel_type; // Setup nibble of the sample
  reg signed [15:0] th_min; // Minimum reading
  reg signed [15:0] th_rated; // Rated input
  reg signed [15:0] th_fault; // Fault limit
  reg open_eff; // Open wire counted as fault
  reg over_now; // Sample at or above fault limit
  reg under_now; // Sample below minimum
  reg warn_now; // Sample in warning band
  reg fault_now; // Sample faulted
  wire [15:0] mem_rdata; // Memory read data
  wire fmt_valid; // Converter result valid
  wire [15:0] fmt_val; // Converted reading
  wire is_chan; // Sample is a sensor channel
  wire is_cj; // Sample is the internal reading
  wire signed [15:0] temp; // Sample as signed tenths
  wire [15:0] status_word; // Channel status word
  wire [15:0] events; // Newly set flags this cycle
  wire mem_rd; // Read aimed at a filled memory word

  assign is_chan = CONV_VALID_I && (CONV_CHAN_I < `CJ_CHAN);
  assign is_cj = CONV_VALID_I && (CONV_CHAN_I == `CJ_CHAN);
  assign temp = CONV_DATA_I;
  assign status_word = {fault, warn};

  // ****************************************
  // Threshold lookup for the sampled channel
  // ****************************************
  always @* begin
    sel_type = CONV_CHAN_I[2] ? type_hi[CONV_CHAN_I[1:0]*4 +: 4] : type_lo[CONV_CHAN_I[1:0]*4 +: 4];
    th_min = `J_MIN;
    th_rated = `J_RATED;
    th_fault = `J_FAULT;
    case (sel_type[2:0])
      `TYPE_K: begin
        th_min = `K_MIN;
        th_rated = `K_RATED;
        th_fault = `K_FAULT;
      end
      `TYPE_E: begin
        th_min = `E_MIN;
        th_rated = `E_RATED;
        th_fault = `E_FAULT;
      end
      `TYPE_T: begin
        th_min = `T_MIN;
        th_rated = `T_RATED;
        th_fault = `T_FAULT;
      end
      `TYPE_S: begin
        th_min = `S_MIN;
        th_rated = `S_RATED;
        th_fault = `S_FAULT;
      end
      `TYPE_R: begin
        th_min = `R_MIN;
        th_rated = `R_RATED;
        th_fault = `R_FAULT;
      end
      `TYPE_B: begin
        th_min = `B_MIN;
        th_rated = `B_RATED;
        th_fault = `B_FAULT;
      end
      default: begin
        // Type J, and linear, which ignores thresholds
        th_min = `J_MIN;
        th_rated = `J_RATED;
        th_fault = `J_FAULT;
      end
    endcase
  end

  // ****************************************
  // Flag decision for the incoming sample
  // ****************************************
  always @* begin
    // Thermocouples always test open; linear only when enabled
    open_eff = CONV_OPEN_I && ((sel_type[2:0] != `TYPE_LIN) || sel_type[3]);
    if (sel_type[2:0] == `TYPE_LIN) begin
      // Linear range: fault on open or full-scale code
      over_now = 1'b0;
      under_now = 1'b0;
      fault_now = open_eff || (CONV_DATA_I == `CODE_LIN_FAULT);
      warn_now = 1'b0;
    end else begin
      over_now = temp >= th_fault;
      under_now = temp < th_min;
      fault_now = over_now || under_now || open_eff;
      // Warning only while no fault stands
      warn_now = (temp > th_rated) && !fault_now;
    end
  end

  // ****************************************
  // Unit conversion, shared by channels and internal reading
  // ****************************************
  temp_format u_fmt (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(is_chan || is_cj),
    .in_temp_i(temp),
    .fahr_i(fmt_cfg[`CFG_FAHR_BIT]),
    .whole_i(fmt_cfg[`CFG_WHOLE_BIT]),
    .out_valid_o(fmt_valid),
    .out_val_o(fmt_val)
  );

  // ****************************************
  // Sample stage, aligned with the converter
  // ****************************************
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      s_chan_ok <= 1'b0;
      s_cj <= 1'b0;
      s_idx <= 3'h0;
      s_over <= 1'b0;
      s_under <= 1'b0;
      s_warn <= 1'b0;
      s_fault <= 1'b0;
      s_lin <= 1'b0;
      s_raw <= 16'h0000;
    end else begin
      s_chan_ok <= is_chan;
      s_cj <= is_cj;
      s_idx <= CONV_CHAN_I[2:0];
      s_over <= over_now || (open_eff && !under_now);
      s_under <= under_now;
      s_warn <= warn_now;
      s_fault <= fault_now;
      s_lin <= sel_type[2:0] == `TYPE_LIN;
      s_raw <= CONV_DATA_I;
    end
  end

  // ****************************************
  // Word to store: saturation codes, raw linear data or converted value
  // ****************************************
  always @* begin
    word_idx = s_cj ? `IDX_INTERNAL : {1'b0, s_idx};
    if (s_cj) begin
      word = fmt_val;
    end else if (s_lin) begin
      word = s_raw;
    end else if (s_over) begin
      word = `CODE_OVER;
    end else if (s_under) begin
      word = `CODE_UNDER;
    end else begin
      // Signed, or unsigned for Type B tenths F above 3276.7
      word = fmt_val;
    end
  end

  word_store #(
    .WIDTH(16),
    .DEPTH(16),
    .AW(4)
  ) u_store (
    .clk_i(REF_CLK_I),
    .we_i(fmt_valid && (s_chan_ok || s_cj)),
    .waddr_i(word_idx),
    .wdata_i(word),
    .re_i(RD_I),
    .raddr_i(ADDR_I),
    .rdata_o(mem_rdata)
  );

  // ****************************************
  // Channel flags, rewritten on each conversion
  // ****************************************
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      warn <= 8'h00;
      fault <= 8'h00;
      written <= 10'h000;
    end else if (fmt_valid && (s_chan_ok || s_cj)) begin
      written[word_idx] <= 1'b1;
      if (s_chan_ok) begin
        warn[s_idx] <= s_warn;
        fault[s_idx] <= s_fault;
      end
    end
  end

  // Flags that go from clear to set in this cycle
  assign events = (fmt_valid && s_chan_ok) ?
    (({8'h00, 8'h01 << s_idx} & {16{s_warn}} & ~{8'h00, warn}) |
     ({8'h01 << s_idx, 8'h00} & {16{s_fault}} & ~{fault, 8'h00})) : 16'h0000;

  // ****************************************
  // Sticky interrupt status, set wins over clear
  // ****************************************
  always @* begin
    next_stat = irq_stat;
    if (WR_I && (ADDR_I == `IDX_IRQ_STAT)) begin
      next_stat = irq_stat & ~WDATA_I;
    end
    next_stat = next_stat | events;
  end

  assign IRQ_O = |(irq_stat & irq_mask);

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      fmt_cfg <= `CFG_RESET;
      type_lo <= `TYPE_RESET;
      type_hi <= `TYPE_RESET;
      irq_mask <= `MASK_RESET;
      irq_stat <= 16'h0000;
    end else begin
      irq_stat <= next_stat;
      if (WR_I) begin
        case (ADDR_I)
          `IDX_CONFIG: begin
            fmt_cfg <= WDATA_I & 16'h0003;
          end
          `IDX_TYPE_LO: begin
            type_lo <= WDATA_I;
          end
          `IDX_TYPE_HI: begin
            type_hi <= WDATA_I;
          end
          `IDX_IRQ_MASK: begin
            irq_mask <= WDATA_I;
          end
          default: begin
            // Input words and status are read only
            irq_mask <= irq_mask;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Register reads, data in the following cycle
  // ****************************************
  assign mem_rd = (ADDR_I < `NUM_WORDS) && (ADDR_I != `IDX_STATUS) && written[ADDR_I];

  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      rd_other <= 1'b1;
      rd_hold <= 16'h0000;
    end else if (RD_I) begin
      rd_other <= !mem_rd;
      case (ADDR_I)
        `IDX_STATUS: begin
          rd_hold <= status_word;
        end
        `IDX_CONFIG: begin
          rd_hold <= fmt_cfg;
        end
        `IDX_TYPE_LO: begin
          rd_hold <= type_lo;
        end
        `IDX_TYPE_HI: begin
          rd_hold <= type_hi;
        end
        `IDX_IRQ_STAT: begin
          rd_hold <= irq_stat;
        end
        `IDX_IRQ_MASK: begin
          rd_hold <= irq_mask;
        end
        default: begin
          // Unfilled words and unmapped indices read zero
          rd_hold <= 16'h0000;
        end
      endcase
    end else begin
      rd_other <= 1'b1;
      rd_hold <= 16'h0000;
    end
  end

  // Ten input words at indices 0 to 9, 16 bits each
  assign RDATA_O = rd_other ? rd_hold : mem_rdata;
endmodule // tc_word_map
`default_nettype wire

// >>> tb/tc_word_map_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module tc_word_map_assertions (
  input wire REF_CLK_I,
  input wire SYS_RST_I,
  input wire [3:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [15:0] RDATA_O,
  input wire IRQ_O,
  input wire CONV_VALID_I,
  input wire [3:0] CONV_CHAN_I,
  input wire [15:0] CONV_DATA_I,
  input wire CONV_OPEN_I
);
  // ****************************************
  // Helper state
  // ****************************************
  logic ovld; // Open sample on a channel of type J to R, non-negative, taken last edge
  logic [2:0] och; // Its channel
  logic [15:0] mask; // Copy of the interrupt mask
  logic [31:0] types; // Copy of both sensor setup words
  // Follow open samples, mask writes and sensor setup writes
  always_ff @(posedge REF_CLK_I) begin
    ovld <= !SYS_RST_I && CONV_VALID_I && CONV_CHAN_I < 4'h8 && CONV_OPEN_I && !CONV_DATA_I[15] &&
      types[CONV_CHAN_I[2:0]*4 +: 3] < 3'h6;
    och <= CONV_CHAN_I[2:0];
    if (SYS_RST_I) begin
      mask <= 16'h0000;
      types <= 32'h00000000;
    end else if (WR_I && ADDR_I == 4'he) begin
      mask <= WDATA_I;
    end else if (WR_I && ADDR_I == 4'hb) begin
      types[15:0] <= WDATA_I;
    end else if (WR_I && ADDR_I == 4'hc) begin
      types[31:16] <= WDATA_I;
    end
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // ****************************************
  // Properties
  // ****************************************
  sequence s_open_word;
    ovld ##1 (RD_I && ADDR_I == {1'b0, $past(och)});
  endsequence
  sequence s_open_stat;
    (ovld && !CONV_VALID_I) ##1 (!CONV_VALID_I) [*2] ##1 (RD_I && ADDR_I == 4'h8);
  endsequence
  property p_rd_idle; !RD_I |=> RDATA_O == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_unmap; RD_I && ADDR_I == 4'hf |=> RDATA_O == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_open_word; s_open_word |=> RDATA_O == 16'h7fff; endproperty
  a_open_word: assert property (p_open_word) else $error("open channel word wrong");
  property p_open_stat; s_open_stat |=> ((RDATA_O >> $past(och, 4)) & 16'h0101) == 16'h0100; endproperty
  a_open_stat: assert property (p_open_stat) else $error("open channel flags wrong");
  property p_excl; RD_I && ADDR_I == 4'h8 |=> (RDATA_O[15:8] & RDATA_O[7:0]) == 8'h00; endproperty
  a_excl: assert property (p_excl) else $error("warning and out-of-range both set");
  property p_rst; $fell(SYS_RST_I) |-> !IRQ_O && RDATA_O == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_mask; mask == 16'h0000 |-> !IRQ_O; endproperty
  a_mask: assert property (p_mask) else $error("interrupt with empty mask");
  property p_w1c;
    WR_I && ADDR_I == 4'hd && WDATA_I == 16'hffff && !CONV_VALID_I && !$past(CONV_VALID_I) |=> !IRQ_O;
  endproperty
  a_w1c: assert property (p_w1c) else $error("interrupt survives full clear");
  property p_irq_rise; $rose(IRQ_O) |-> $past(CONV_VALID_I, 2) || $past(WR_I && ADDR_I == 4'he); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
endmodule // tc_word_map_assertions
bind tc_word_map tc_word_map_assertions u_chk (.*);
`default_nettype wire

// >>> tb/conv_source.sv
`timescale 1ns/10ps
`default_nettype none
// Front end model: one-cycle sample pulse, lines scrambled between pulses
module conv_source (
  input wire clk_i,
  input wire go_i,
  input wire [3:0] chan_i,
  input wire [15:0] data_i,
  input wire open_i,
  output logic valid_o,
  output logic [3:0] chan_o,
  output logic [15:0] data_o,
  output logic open_o
);
  initial {valid_o, chan_o, data_o, open_o} = 22'h0;
  // Outside a pulse the lines show the inverse of their last value
  always @(posedge clk_i) begin
    valid_o <= go_i;
    chan_o <= go_i ? chan_i : ~chan_o;
    data_o <= go_i ? data_i : ~data_o;
    open_o <= go_i ? open_i : ~open_o;
  end
endmodule // conv_source
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic REF_CLK_I = 1'b0;
  logic SYS_RST_I = 1'b1;
  logic [3:0] ADDR_I = 4'h0;
  logic [15:0] WDATA_I = 16'h0000;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  wire [15:0] RDATA_O;
  wire IRQ_O;
  wire cv, co;
  wire [3:0] cc;
  wire [15:0] cd;
  logic go = 1'b0;
  logic [3:0] gch = 4'h0;
  logic [15:0] gd = 16'h0000;
  logic gop = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] lfsr = 32'h6560;
  logic [15:0] st = 16'h0000; // Expected status word
  logic [15:0] ev = 16'h0000; // Expected interrupt status
  logic [15:0] rv;
  logic signed [15:0] v;
  logic signed [15:0] cn [7] = '{16'sd7600, 16'sd7601, 16'sd7786, 16'sd7787, -16'sd2285, -16'sd2286, 16'sd0};
  // Format table: config, channel, sample, expected word
  logic [15:0] cf [6] = '{16'h1, 16'h1, 16'h1, 16'h2, 16'h2, 16'h2};
  logic [3:0] tch [6] = '{4'h0, 4'h0, 4'h8, 4'h1, 4'h8, 4'h0};
  logic [15:0] tx [6] = '{16'd1234, -16'sd1239, 16'd255, 16'd1000, 16'd250, 16'd18200};
  logic [15:0] te [6] = '{16'h007b, 16'hff85, 16'h0019, 16'h0848, 16'h0302, 16'h8138};
  tc_word_map DUT (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .CONV_VALID_I(cv),
    .CONV_CHAN_I(cc), .CONV_DATA_I(cd), .CONV_OPEN_I(co));
  conv_source src (.clk_i(REF_CLK_I), .go_i(go), .chan_i(gch), .data_i(gd), .open_i(gop),
    .valid_o(cv), .chan_o(cc), .data_o(cd), .open_o(co));
  initial forever #20 REF_CLK_I = ~REF_CLK_I;
  // Cut a hang short
  always @(posedge REF_CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  function logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Fault and warning of a type J sample, tenths C
  function logic [1:0] flg(input logic signed [15:0] x, input logic o);
    flg[1] = o || x >= 16'sd7787 || x < -16'sd2285;
    flg[0] = !flg[1] && x > 16'sd7600;
  endfunction
  function logic [15:0] ew(input logic signed [15:0] x, input logic o);
    ew = (x < -16'sd2285) ? 16'h8001 : (o || x >= 16'sd7787) ? 16'h7fff : x;
  endfunction
  task wr(input logic [3:0] a, input logic [15:0] d);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge REF_CLK_I) WR_I <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] d);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge REF_CLK_I) RD_I <= 1'b0;
    @(posedge REF_CLK_I) d = RDATA_O;
  endtask
  // Returns one edge after the design takes the sample, once the word is stored
  task sample(input logic [3:0] ch, input logic [15:0] x, input logic o);
    go <= 1'b1;
    gch <= ch;
    gd <= x;
    gop <= o;
    @(posedge REF_CLK_I) go <= 1'b0;
    @(posedge REF_CLK_I);
    @(posedge REF_CLK_I);
  endtask
  task chk_ch(input logic [2:0] ch, input logic [15:0] x, input logic o);
    logic [1:0] f;
    logic [15:0] d, nb;
    f = flg(x, o);
    nb = {7'h0, f[1], 7'h0, f[0]} << ch;
    sample({1'b0, ch}, x, o);
    rd({1'b0, ch}, d);
    `CHK(d, ew(x, o))
    ev |= nb & ~st;
    st = (st & ~(16'h0101 << ch)) | nb;
    rd(4'h8, d);
    `CHK(d, st)
  endtask
  task give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge REF_CLK_I);
    SYS_RST_I <= 1'b0;
    @(posedge REF_CLK_I);
    rd(4'h9, rv);
    `CHK(rv, 16'h0000)
    rd(4'hf, rv);
    `CHK(rv, 16'h0000)
    // Limits first, then random samples
    for (int i = 0; i < 48; i++) begin
      lfsr = nxt(lfsr);
      v = (i < 7) ? cn[i] : {2'b00, lfsr[13:0]} - 16'sd3000;
      chk_ch(lfsr[18:16], v, (i >= 7) && lfsr[23:20] == 4'h0);
    end
    rd(4'hd, rv);
    `CHK(rv, ev)
    `CHK(IRQ_O, 1'b0)
    wr(4'he, 16'hffff);
    rd(4'he, rv);
    `CHK(rv, 16'hffff)
    `CHK(IRQ_O, ev != 16'h0000)
    wr(4'hd, 16'hffff);
    rd(4'hd, rv);
    `CHK(rv, 16'h0000)
    ev = 16'h0000;
    chk_ch(3'h3, 16'sd100, 1'b0);
    chk_ch(3'h3, 16'sd100, 1'b1);
    `CHK(IRQ_O, 1'b1)
    rd(4'hd, rv);
    `CHK(rv, ev)
    wr(4'h3, 16'h1234);
    rd(4'h3, rv);
    `CHK(rv, 16'h7fff)
    // Resolution, scale, internal reading and the unsigned case
    for (int i = 0; i < 6; i++) begin
      if (i == 5) begin
        wr(4'hb, 16'h0006);
        @(posedge REF_CLK_I);
      end
      wr(4'ha, cf[i]);
      sample(tch[i], tx[i], 1'b0);
      rd((tch[i] == 4'h8) ? 4'h9 : tch[i], rv);
      `CHK(rv, te[i])
    end
    // Linear ranges: raw data, open test only where enabled
    wr(4'hb, 16'h7f06);
    sample(4'h2, 16'h1234, 1'b1);
    rd(4'h2, rv);
    `CHK(rv, 16'h1234)
    sample(4'h3, 16'h4321, 1'b1);
    rd(4'h3, rv);
    `CHK(rv, 16'h4321)
    rd(4'h8, rv);
    `CHK({rv[11:10], rv[3:2]}, 4'h4)
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
